// ===== rtl/lkc_cmd.sv
// Purpose: pin-type, new unit key and stored link-key command handling
// Assumes: one command at a time; write entries follow their command
// Notes: one key per key-return event
//
// Operation
// - opcode 0x000A stores pin type, 0x00 variable, 0x01 fixed, used in pairing.
// - every command answers one status byte, zero success, nonzero error code.
// - each finished command emits command-complete unless that event is masked.
// - opcode 0x000B, no parameters, creates a replacement unit key.
// - new unit key derived from a freshly generated random seed.
// - later connections use new unit key, open ones keep the old one.
// - combination-key-only device treats new-unit-key command as no effect.
// - opcode 0x000D carries six-byte peer address and one-byte read-all flag.
// - flag 0x00 reads one address, 0x01 reads all, others reserved.
// - keys go out in zero or more return events before completion.
// - read answers store capacity and number of keys read, 16 bits each.
// - opcode 0x0011 carries count, addresses and sixteen-byte keys paired by index.
// - keys stored in list order; once full, remaining keys are dropped unless their address is already stored.
// - write answers how many keys were actually stored.
// - store entries are added only by the stored-key write command.
`timescale 1ns/100ps
`default_nettype none
module lkc_cmd #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [9:0] cmd_op_i,
  input wire logic [7:0] cmd_pin_type_i,
  input wire logic [47:0] cmd_peer_addr_i,
  input wire logic [7:0] cmd_read_all_i,
  input wire logic [7:0] cmd_num_keys_i,
  // write list entries
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [47:0] wr_addr_i,
  input wire logic [127:0] wr_key_i,
  // key-return events
  output logic rk_valid_o,
  output logic [47:0] rk_addr_o,
  output logic [127:0] rk_key_o,
  // command-complete events
  input wire logic cc_mask_i,
  output logic cc_valid_o,
  output logic [9:0] cc_op_o,
  output logic [7:0] cc_status_o,
  output logic [15:0] cc_par0_o,
  output logic [15:0] cc_par1_o,
  // pairing and unit keys
  input wire logic use_unit_keys_i,
  output logic [7:0] pin_type_o,
  output logic [127:0] unit_key_o,
  output logic [127:0] unit_key_prev_o
);
  import lkc_pkg::*;
  localparam int IW = $clog2(DEPTH);
  lkc_state_t state_q, state_d;
  logic acc;
  logic wr_fire;
  logic [9:0] op_q;
  logic [7:0] status_q;
  logic all_q;
  logic [47:0] peer_q;
  logic [7:0] cnt_q;
  logic [7:0] nw_q;
  logic [15:0] nr_q;
  logic [IW-1:0] idx_q;
  logic [DEPTH-1:0] vld_q;
  logic [47:0] addr_q [DEPTH];
  logic [127:0] key_q [DEPTH];
  logic [DEPTH-1:0] hit_w, free_w;
  logic [IW-1:0] slot;
  logic slot_ok;
  logic [31:0] lfsr_q;
  logic [127:0] ukey_new;
  logic rd_hit;
  assign acc = cmd_valid_i && cmd_ready_o;
  assign wr_fire = wr_valid_i && wr_ready_o;
  // ==========================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      LKC_IDLE: begin
        if (acc) begin
          if (cmd_op_i == LKC_OP_KEY_WR) begin
            state_d = (cmd_num_keys_i == 8'h00) ? LKC_DONE : LKC_WRITE;
          end else if (cmd_op_i == LKC_OP_KEY_RD &&
                       cmd_read_all_i <= LKC_RD_ALL) begin
            state_d = LKC_READ;
          end else begin
            state_d = LKC_DONE;
          end
        end
      end
      LKC_WRITE: if (wr_fire && cnt_q == 8'h01) state_d = LKC_DONE;
      LKC_READ: if (idx_q == IW'(DEPTH - 1)) state_d = LKC_DONE;
      LKC_DONE: state_d = LKC_IDLE;
      default: state_d = LKC_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= LKC_IDLE;
      cmd_ready_o <= 1'b0;
      wr_ready_o <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_ready_o <= (state_d == LKC_IDLE);
      wr_ready_o <= (state_d == LKC_WRITE);
    end
  end

  // ==========================================================
  // command capture and status
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_q <= 10'h000;
      status_q <= LKC_ST_OK;
      all_q <= 1'b0;
      peer_q <= 48'h0000_0000_0000;
    end else if (acc) begin
      op_q <= cmd_op_i;
      all_q <= (cmd_read_all_i == LKC_RD_ALL);
      peer_q <= cmd_peer_addr_i;
      if (cmd_op_i != LKC_OP_PIN_WR && cmd_op_i != LKC_OP_NEW_UKEY &&
          cmd_op_i != LKC_OP_KEY_RD && cmd_op_i != LKC_OP_KEY_WR) begin
        status_q <= LKC_ST_UNKNOWN;
      end else if ((cmd_op_i == LKC_OP_KEY_RD &&
                    cmd_read_all_i > LKC_RD_ALL) ||
                   (cmd_op_i == LKC_OP_PIN_WR &&
                    cmd_pin_type_i > LKC_PIN_FIXED)) begin
        status_q <= LKC_ST_BAD_PARAM;
      end else begin
        status_q <= LKC_ST_OK;
      end
    end
  end

  // ==========================================================
  // pin type
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_type_o <= LKC_PIN_RST;
    end else if (acc && cmd_op_i == LKC_OP_PIN_WR &&
                 cmd_pin_type_i <= LKC_PIN_FIXED) begin
      pin_type_o <= cmd_pin_type_i;
    end
  end

  // ==========================================================
  // unit key: free-running seed, previous key kept for open links
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lfsr_q <= LKC_LFSR_RST;
    end else begin
      lfsr_q <= {lfsr_q[30:0],
                 lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    end
  end
  assign ukey_new = unit_key_o ^ {lfsr_q, lfsr_q ^ LKC_MIX_K,
                                  ~lfsr_q, {lfsr_q[15:0], lfsr_q[31:16]}};
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unit_key_o <= LKC_UKEY_RST;
      unit_key_prev_o <= LKC_UKEY_RST;
    end else if (acc && cmd_op_i == LKC_OP_NEW_UKEY &&
                 use_unit_keys_i) begin
      unit_key_o <= ukey_new;
      unit_key_prev_o <= unit_key_o;
    end
  end

  // ==========================================================
  // key store: hit replaces in place, else lowest free slot
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    assign hit_w[g] = vld_q[g] && (addr_q[g] == wr_addr_i);
    assign free_w[g] = !vld_q[g];
  end
  always_comb begin
    slot = '0;
    slot_ok = 1'b0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (free_w[i]) begin
        slot = IW'(i);
        slot_ok = 1'b1;
      end
    end
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (hit_w[i]) begin
        slot = IW'(i);
        slot_ok = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vld_q <= '0;
    end else if (wr_fire && slot_ok) begin
      vld_q[slot] <= 1'b1;
    end
  end
  // table contents need no reset; valid flags guard them
  always_ff @(posedge sys_clk_i) begin
    if (wr_fire && slot_ok) begin
      addr_q[slot] <= wr_addr_i;
      key_q[slot] <= wr_key_i;
    end
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 8'h00;
      nw_q <= 8'h00;
    end else if (acc) begin
      cnt_q <= cmd_num_keys_i;
      nw_q <= 8'h00;
    end else if (wr_fire) begin
      cnt_q <= cnt_q - 8'h01;
      if (slot_ok) nw_q <= nw_q + 8'h01;
    end
  end

  // ==========================================================
  // read scan, one key per return event
  assign rd_hit = vld_q[idx_q] && (all_q || addr_q[idx_q] == peer_q);
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idx_q <= '0;
      nr_q <= 16'h0000;
      rk_valid_o <= 1'b0;
      rk_addr_o <= 48'h0000_0000_0000;
      rk_key_o <= '0;
    end else begin
      rk_valid_o <= 1'b0;
      if (acc) begin
        idx_q <= '0;
        nr_q <= 16'h0000;
      end else if (state_q == LKC_READ) begin
        idx_q <= idx_q + IW'(1);
        if (rd_hit) begin
          rk_valid_o <= 1'b1;
          rk_addr_o <= addr_q[idx_q];
          rk_key_o <= key_q[idx_q];
          nr_q <= nr_q + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // command complete
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cc_valid_o <= 1'b0;
      cc_op_o <= 10'h000;
      cc_status_o <= LKC_ST_OK;
      cc_par0_o <= 16'h0000;
      cc_par1_o <= 16'h0000;
    end else begin
      cc_valid_o <= (state_q == LKC_DONE) && !cc_mask_i;
      if (state_q == LKC_DONE) begin
        cc_op_o <= op_q;
        cc_status_o <= status_q;
        cc_par0_o <= 16'h0000;
        cc_par1_o <= 16'h0000;
        if (op_q == LKC_OP_KEY_RD) begin
          cc_par0_o <= 16'(DEPTH);
          cc_par1_o <= nr_q;
        end else if (op_q == LKC_OP_KEY_WR) begin
          cc_par0_o <= {8'h00, nw_q};
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_pin;
    acc && cmd_op_i == LKC_OP_PIN_WR && cmd_pin_type_i == LKC_PIN_FIXED
      |=> pin_type_o == LKC_PIN_FIXED;
  endproperty
  a_pin: assert property (p_pin) else $error("pin type not stored");
  property p_unknown;
    acc && cmd_op_i == 10'h3FF |=> ##1 cc_status_o == LKC_ST_UNKNOWN;
  endproperty
  a_unknown: assert property (p_unknown) else $error("bad status");
  property p_cc;
    state_q == LKC_DONE && !cc_mask_i |=> cc_valid_o && cc_op_o == op_q;
  endproperty
  a_cc: assert property (p_cc) else $error("no completion event");
  property p_newkey;
    acc && cmd_op_i == LKC_OP_NEW_UKEY && use_unit_keys_i
      |=> unit_key_prev_o == $past(unit_key_o) &&
          unit_key_o != $past(unit_key_o);
  endproperty
  a_newkey: assert property (p_newkey) else $error("unit key not renewed");
  property p_nokey;
    !(acc && cmd_op_i == LKC_OP_NEW_UKEY && use_unit_keys_i)
      |=> $stable(unit_key_o) && $stable(unit_key_prev_o);
  endproperty
  a_nokey: assert property (p_nokey) else $error("unit key changed");
  property p_resv;
    acc && cmd_op_i == LKC_OP_KEY_RD && cmd_read_all_i > LKC_RD_ALL
      |=> state_q == LKC_DONE && status_q == LKC_ST_BAD_PARAM;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved flag taken");
  property p_order;
    cc_valid_o |-> !rk_valid_o ##1 !rk_valid_o;
  endproperty
  a_order: assert property (p_order) else $error("key after completion");
  property p_cap;
    cc_valid_o && cc_op_o == LKC_OP_KEY_RD && cc_status_o == LKC_ST_OK
      |-> cc_par0_o == 16'(DEPTH);
  endproperty
  a_cap: assert property (p_cap) else $error("capacity wrong");
  property p_add;
    state_q != LKC_WRITE |=> (vld_q & ~$past(vld_q)) == '0;
  endproperty
  a_add: assert property (p_add) else $error("entry added outside write");
  property p_full;
    wr_fire && vld_q == '1 && hit_w == '0 |=> $stable(vld_q) && $stable(nw_q);
  endproperty
  a_full: assert property (p_full) else $error("stored into full table");
  c_write: cover property (acc && cmd_op_i == LKC_OP_KEY_WR ##[1:20] cc_valid_o);
  c_rdall: cover property (rk_valid_o ##1 rk_valid_o);
  c_full: cover property (wr_fire && !slot_ok);
  c_ukey: cover property (acc && cmd_op_i == LKC_OP_NEW_UKEY);
endmodule // lkc_cmd
`default_nettype wire

// ===== rtl/lkc_pkg.sv
// Purpose: constants shared by the pin-type and link-key command block
// Assumes: opcode fields arrive as 10-bit command fields
// Notes: status codes other than success are local choices
package lkc_pkg;
  // ==========================================================
  // command fields
  localparam logic [9:0] LKC_OP_PIN_WR = 10'h00A;
  localparam logic [9:0] LKC_OP_NEW_UKEY = 10'h00B;
  localparam logic [9:0] LKC_OP_KEY_RD = 10'h00D;
  localparam logic [9:0] LKC_OP_KEY_WR = 10'h011;
  // ==========================================================
  // parameter values
  localparam logic [7:0] LKC_PIN_VARIABLE = 8'h00;
  localparam logic [7:0] LKC_PIN_FIXED = 8'h01;
  localparam logic [7:0] LKC_RD_ONE = 8'h00;
  localparam logic [7:0] LKC_RD_ALL = 8'h01;
  // ==========================================================
  // status codes
  localparam logic [7:0] LKC_ST_OK = 8'h00;
  localparam logic [7:0] LKC_ST_UNKNOWN = 8'h01;
  localparam logic [7:0] LKC_ST_BAD_PARAM = 8'h12;
  // ==========================================================
  // reset values and unit-key mix constant
  localparam logic [7:0] LKC_PIN_RST = 8'h00;
  localparam logic [31:0] LKC_LFSR_RST = 32'hACE1_0001;
  localparam logic [127:0] LKC_UKEY_RST = {4{32'h0000_0000}};
  localparam logic [31:0] LKC_MIX_K = 32'h9E37_79B9;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    LKC_IDLE,
    LKC_WRITE,
    LKC_READ,
    LKC_DONE
  } lkc_state_t;
endpackage

// ===== tb/lkc_host_model.sv
// Purpose: host side that issues commands and takes events
// Assumes: one command at a time; list entries follow their command
// Notes: released lines carry inverted data so stale values never match
`timescale 1ns/100ps
`default_nettype none
module lkc_host_model (
  // clock
  input wire logic sys_clk_i,
  // command
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output logic [9:0] cmd_op_o,
  output logic [7:0] cmd_pin_type_o,
  output logic [47:0] cmd_peer_addr_o,
  output logic [7:0] cmd_read_all_o,
  output logic [7:0] cmd_num_keys_o,
  // list entries
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [47:0] wr_addr_o,
  output logic [127:0] wr_key_o,
  // events and bookkeeping
  input wire logic rk_valid_i,
  input wire logic cc_valid_i,
  output int rk_cnt_o,
  output logic cc_seen_o,
  output logic hung_o
);
  import lkc_pkg::*;
  // ==========================================================
  // idle values and event counting
  initial begin
    {cmd_valid_o, wr_valid_o, cc_seen_o, hung_o} = 4'h0;
    {cmd_op_o, cmd_pin_type_o, cmd_peer_addr_o} = '0;
    {cmd_read_all_o, cmd_num_keys_o, wr_addr_o, wr_key_o} = '0;
    rk_cnt_o = 0;
  end
  always @(posedge sys_clk_i) begin
    if (rk_valid_i === 1'b1) begin
      rk_cnt_o = rk_cnt_o + 1;
    end
  end
  // ==========================================================
  // one command, its list entries, then wait for completion
  task automatic issue(input logic [9:0] op, input logic [7:0] pin,
      input logic [47:0] addr, input logic [7:0] flag,
      input logic [7:0] n, input logic [47:0] ab, input logic [127:0] kb);
    int i;
    int t;
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_op_o <= op;
    cmd_pin_type_o <= pin;
    cmd_peer_addr_o <= addr;
    cmd_read_all_o <= flag;
    cmd_num_keys_o <= n;
    rk_cnt_o = 0;
    cc_seen_o = 1'b0;
    t = 0;
    do begin
      @(posedge sys_clk_i);
      t++;
    end while (cmd_ready_i !== 1'b1 && t < 50);
    hung_o = (t >= 50);
    cmd_valid_o <= 1'b0;
    {cmd_op_o, cmd_pin_type_o, cmd_peer_addr_o} <= ~{op, pin, addr};
    {cmd_read_all_o, cmd_num_keys_o} <= ~{flag, n};
    // entry i pairs address and key in the same cycle
    for (i = 0; op == LKC_OP_KEY_WR && i < n; i++) begin
      wr_valid_o <= 1'b1;
      wr_addr_o <= ab + i;
      wr_key_o <= kb + i;
      t = 0;
      do begin
        @(posedge sys_clk_i);
        t++;
      end while (wr_ready_i !== 1'b1 && t < 50);
      hung_o = hung_o | (t >= 50);
    end
    wr_valid_o <= 1'b0;
    wr_addr_o <= ~wr_addr_o;
    wr_key_o <= ~wr_key_o;
    t = 0;
    do begin
      @(posedge sys_clk_i);
      t++;
      if (cc_valid_i === 1'b1) begin
        cc_seen_o = 1'b1;
      end
    end while ((cmd_ready_i !== 1'b1 || t < 2) && t < 50);
    hung_o = hung_o | (t >= 50);
  endtask
endmodule // lkc_host_model
`default_nettype wire

// ===== tb/lkc_cmd_test.sv
// Purpose: self-checking bench for the command block
// Assumes: small key store so that the full case is reached quickly
// Notes: expected values come from the list base and entry index
`timescale 1ns/100ps
`default_nettype none
module lkc_cmd_test;
  import lkc_pkg::*;
  localparam int DEPTH = 4;
  localparam logic [47:0] AB = 48'hC0DE_0000_0100;
  localparam logic [127:0] KB = {4{32'h5A5A_0000}};
  localparam logic [127:0] KB2 = {4{32'h0F0F_1234}};
  logic sys_clk, arst_n, cc_mask, use_uk, cmd_valid, cmd_ready;
  logic wr_valid, wr_ready, rk_valid, cc_valid, cc_seen, hung;
  logic [9:0] cmd_op, cc_op;
  logic [7:0] pin, flag, num, cc_status, pin_type;
  logic [47:0] peer, wr_addr, rk_addr;
  logic [127:0] wr_key, rk_key, ukey, ukey_prev, k, kp;
  logic [15:0] par0, par1;
  logic [7:0] p;
  int rk_cnt, err_total, tests_run, i;
  lkc_cmd #(.DEPTH(DEPTH)) i_lkc_cmd (.sys_clk_i(sys_clk),
    .arst_n_i(arst_n), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_op_i(cmd_op), .cmd_pin_type_i(pin), .cmd_peer_addr_i(peer),
    .cmd_read_all_i(flag), .cmd_num_keys_i(num), .wr_valid_i(wr_valid),
    .wr_ready_o(wr_ready), .wr_addr_i(wr_addr), .wr_key_i(wr_key),
    .rk_valid_o(rk_valid), .rk_addr_o(rk_addr), .rk_key_o(rk_key),
    .cc_mask_i(cc_mask), .cc_valid_o(cc_valid), .cc_op_o(cc_op),
    .cc_status_o(cc_status), .cc_par0_o(par0), .cc_par1_o(par1),
    .use_unit_keys_i(use_uk), .pin_type_o(pin_type),
    .unit_key_o(ukey), .unit_key_prev_o(ukey_prev));
  lkc_host_model i_lkc_host_model (.sys_clk_i(sys_clk),
    .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready), .cmd_op_o(cmd_op),
    .cmd_pin_type_o(pin), .cmd_peer_addr_o(peer), .cmd_read_all_o(flag),
    .cmd_num_keys_o(num), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
    .wr_addr_o(wr_addr), .wr_key_o(wr_key), .rk_valid_i(rk_valid),
    .cc_valid_i(cc_valid), .rk_cnt_o(rk_cnt), .cc_seen_o(cc_seen),
    .hung_o(hung));
  // ==========================================================
  // clock, checks and verdict
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a lost handshake ends the run; completion must follow the mask
  task automatic run(input logic [9:0] op, input logic [7:0] pv,
      input logic [47:0] ad, input logic [7:0] fl, input logic [7:0] n,
      input logic [127:0] kb, input logic [7:0] st);
    i_lkc_host_model.issue(op, pv, ad, fl, n, AB, kb);
    if (hung) begin
      err_total++;
      test_done();
    end
    chk(cc_seen, !cc_mask);
    if (cc_seen) begin
      chk(cc_op, op);
      chk(cc_status, st);
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {arst_n, cc_mask, use_uk, err_total, tests_run} = {3'b001, 64'h0};
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk({pin_type, ukey}, '0);
    // reserved value first, so a wrong store shows as nonzero
    for (i = 0; i < 3; i++) begin
      p = 8'(2 - i);
      run(LKC_OP_PIN_WR, p, '0, '0, '0, KB,
        (p > 8'h01) ? LKC_ST_BAD_PARAM : LKC_ST_OK);
      chk(pin_type, (p > 8'h01) ? 8'h00 : p);
    end
    run(10'h3FF, '0, '0, '0, '0, KB, LKC_ST_UNKNOWN);
    for (i = 0; i < 2; i++) begin
      k = ukey;
      run(LKC_OP_NEW_UKEY, '0, '0, '0, '0, KB, LKC_ST_OK);
      chk(ukey_prev, k);
      chk(ukey !== k, 1'b1);
    end
    use_uk <= 1'b0;
    {k, kp} = {ukey, ukey_prev};
    run(LKC_OP_NEW_UKEY, '0, '0, '0, '0, KB, LKC_ST_OK);
    chk({ukey, ukey_prev}, {k, kp});
    // nothing above may have added a store entry
    run(LKC_OP_KEY_RD, '0, '0, LKC_RD_ALL, '0, KB, LKC_ST_OK);
    chk({rk_cnt, par0, par1}, {32'h0, DEPTH[15:0], 16'h0});
    // list longer than the store: the tail must be dropped
    run(LKC_OP_KEY_WR, '0, '0, '0, DEPTH + 2, KB, LKC_ST_OK);
    chk(par0, DEPTH);
    run(LKC_OP_KEY_RD, '0, '0, LKC_RD_ALL, '0, KB, LKC_ST_OK);
    chk({rk_cnt, par1}, {DEPTH, DEPTH[15:0]});
    chk({rk_addr, rk_key}, {AB + DEPTH - 1, KB + DEPTH - 1});
    run(LKC_OP_KEY_RD, '0, AB + 1, LKC_RD_ONE, '0, KB, LKC_ST_OK);
    chk({rk_cnt, par1, rk_key}, {32'h1, 16'h1, KB + 1});
    run(LKC_OP_KEY_RD, '0, AB + DEPTH, LKC_RD_ONE, '0, KB, LKC_ST_OK);
    chk({rk_cnt, par1}, 48'h0);
    run(LKC_OP_KEY_RD, '0, AB, 8'h02, '0, KB, LKC_ST_BAD_PARAM);
    chk(rk_cnt, 0);
    // a key for a stored address replaces that entry in a full store
    run(LKC_OP_KEY_WR, '0, '0, '0, 8'h01, KB2, LKC_ST_OK);
    chk(par0, 16'h0001);
    run(LKC_OP_KEY_RD, '0, AB, LKC_RD_ONE, '0, KB, LKC_ST_OK);
    chk({rk_cnt, rk_key}, {32'h1, KB2});
    cc_mask <= 1'b1;
    run(LKC_OP_PIN_WR, LKC_PIN_FIXED, '0, '0, '0, KB, LKC_ST_OK);
    chk(pin_type, LKC_PIN_FIXED);
    cc_mask <= 1'b0;
    run(LKC_OP_KEY_WR, '0, '0, '0, 8'h00, KB, LKC_ST_OK);
    chk(par0, 16'h0000);
    test_done();
  end
endmodule // lkc_cmd_test
`default_nettype wire
